// ---- logic/trace_buffer_regs.svh ----
// register offsets, field positions and reset values of the trace buffer writer
`ifndef TRACE_BUFFER_REGS_SVH
`define TRACE_BUFFER_REGS_SVH
`define TB_CTRL     8'h00
`define TB_STAT     8'h04
`define TB_PTR_LO   8'h08
`define TB_PTR_HI   8'h0c
`define TB_BASE_LO  8'h10
`define TB_BASE_HI  8'h14
`define TB_LIM_LO   8'h18
`define TB_LIM_HI   8'h1c
`define TB_TRG      8'h20
`define TB_ATTR     8'h24
`define TB_C_EN     0
`define TB_C_BYP    1
`define TB_C_TBI    2
`define TB_C_LPA    3
`define TB_C_FILL   4
`define TB_S_STOP   0
`define TB_S_WRAP   1
`define TB_S_FAULT  2
`define TB_S_FULL   3
`define TB_GRAN     12
`define TB_TOP_LPA  51
`define TB_TOP_STD  47
`define TB_DEV_ATTR 8'h00
`define TB_CTRL_RST 5'h00
`define TB_STAT_RST 4'h0
`define TB_RESP_OK  2'h0
`define TB_RESP_ERR 2'h2
`endif

// ---- logic/trace_buffer_pkg.sv ----
// types shared by the trace buffer writer files
package trace_buffer_pkg;
   // collection state of the unit
   typedef enum logic [1:0] {ST_OFF, ST_RUN, ST_STOP} tbState_t;
   // a full 64-bit buffer address
   typedef logic [63:0] addr_t;
endpackage : trace_buffer_pkg

// ---- logic/addr_check.sv ----
// address-size check of the write pointer when translation is bypassed
`timescale 1ns/1ps
`include "trace_buffer_regs.svh"
module addr_check
   import trace_buffer_pkg::*;
#(
   parameter int PA_MAX = 48   // supported physical address width
)
(
   input  wire addr_t ptr,       // current write pointer
   input  wire logic  largePa,   // large physical addressing present
   output addr_t      physAddr,  // pointer with bits above top cleared
   output logic       sizeFault  // pointer bits [top:PA_MAX] nonzero
);
   // walk every bit against the top index and the supported width
   always_comb
   begin
      int top;
      top = largePa ? `TB_TOP_LPA : `TB_TOP_STD;
      sizeFault = 1'b0;
      physAddr = ptr;
      for (int i = 0; i < 64; i++)
      begin
         if (i >= PA_MAX && i <= top && ptr[i])
            sizeFault = 1'b1;
         if (i > top)
            physAddr[i] = 1'b0;
      end
   end
endmodule : addr_check

// ---- logic/trace_buffer_writer.sv ----
// trace buffer writer: trace bytes into a circular memory buffer
//
// Decided for this implementation: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
`include "trace_buffer_regs.svh"
module trace_buffer_writer
   import trace_buffer_pkg::*;
#(
   parameter int PA_MAX = 48  // max_phys_addr_width
)
(
   input  wire logic        mclk,         // processor clock
   input  wire logic        nrst,         // async reset, active low
   input  wire logic [7:0]  awaddr,       // axi write address
   input  wire logic        awvalid,
   output logic             awready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   input  wire logic        wvalid,
   output logic             wready,
   output logic [1:0]       bresp,
   output logic             bvalid,
   input  wire logic        bready,
   input  wire logic [7:0]  araddr,
   input  wire logic        arvalid,
   output logic             arready,
   output logic [31:0]      rdata,
   output logic [1:0]       rresp,
   output logic             rvalid,
   input  wire logic        rready,
   input  wire logic        selfHostedOk, // self_hosted_trace_allowed pin
   input  wire logic        traceValid,   // trace byte offered
   input  wire logic [7:0]  traceData,
   output logic             traceReady,   // byte accepted when both high
   output addr_t            xlateVa,      // address to translate
   output logic             xlateReq,     // translation wanted
   input  wire addr_t       xlatePa,      // translated address
   input  wire logic [7:0]  xlateAttr,    // translated attributes
   input  wire logic        xlateFault,   // translation fault
   input  wire logic        stage1On,     // stage one translation enabled
   output logic             memValid,     // byte write request
   output addr_t            memAddr,
   output logic [7:0]       memData,
   output logic [7:0]       memAttr,
   input  wire logic        memReady,
   output logic             wrapEvent,    // pointer_wrap_event pulse
   output logic             mgmtIrq       // management interrupt request
);
   // software-visible state
   logic [4:0]  ctrl_r;   // enable, bypass, tbi, large pa, fill mode
   logic [3:0]  stat_r;   // stopped, wrap, fault, full
   addr_t       ptr_r;    // write_pointer_field
   logic [51:0] baseF_r;  // base_address_field
   logic [51:0] limF_r;   // limit_address_field
   logic [31:0] trg_r;    // trigger_count_field
   logic [7:0]  attr_r;   // buffer_attribute_register
   // bus channel state
   logic        awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
   logic [1:0]  bresp_r, rresp_r;
   logic [31:0] rdata_r, wData_r;
   logic [7:0]  awAddr_r;
   logic [3:0]  wStrb_r;
   // datapath outputs
   logic        traceReady_r, memValid_r, wrapEvent_r, mgmtIrq_r, xlateReq_r;
   addr_t       memAddr_r, xlateVa_r;
   logic [7:0]  memData_r, memAttr_r;
   // pin synchroniser
   logic        selfOk_s1, selfOk_s2;
   // combinational terms
   logic        regWr, accept, issue, faultNow, wrapNow, sizeFault, chkFault;
   logic        en, memBusyNxt;
   logic [3:0]  statNxt;  // status after software write and hardware sets
   logic [31:0] merged;
   addr_t       ptrNxt, basePtr, limPtr, physAddr;
   tbState_t    state;

   // mapped offsets answer okay, others slave error
   function automatic logic isMapped(input logic [7:0] a);
      isMapped = (a[1:0] == 2'h0) && (a <= `TB_ATTR);
   endfunction : isMapped

   // current value of a register word
   function automatic logic [31:0] regRead(input logic [7:0] a);
      case (a)
         `TB_CTRL:    regRead = {27'h0, ctrl_r};
         `TB_STAT:    regRead = {28'h0, stat_r};
         `TB_PTR_LO:  regRead = ptr_r[31:0];
         `TB_PTR_HI:  regRead = ptr_r[63:32];
         `TB_BASE_LO: regRead = {baseF_r[19:0], 12'h000};
         `TB_BASE_HI: regRead = baseF_r[51:20];
         `TB_LIM_LO:  regRead = {limF_r[19:0], 12'h000};
         `TB_LIM_HI:  regRead = limF_r[51:20];
         `TB_TRG:     regRead = trg_r;
         `TB_ATTR:    regRead = {24'h0, attr_r};
         default:     regRead = 32'h0;
      endcase
   endfunction : regRead

   // byte-lane merge of a write into the old word
   function automatic logic [31:0] wmerge(input logic [31:0] o, input logic [31:0] d,
                                          input logic [3:0] s);
      for (int b = 0; b < 4; b++)
         wmerge[b*8 +: 8] = s[b] ? d[b*8 +: 8] : o[b*8 +: 8];
   endfunction : wmerge

   // pointers from the granule-shifted fields
   assign basePtr = {baseF_r, 12'h000};
   assign limPtr  = {limF_r, 12'h000};
   assign en      = selfOk_s2 & ctrl_r[`TB_C_EN];
   assign regWr   = !awready_r && !wready_r && !bvalid_r;
   // comb process so that changes of the register words are seen
   always_comb merged = wmerge(regRead(awAddr_r), wData_r, wStrb_r);
   // bypass uses the size check, otherwise the translator's fault
   assign sizeFault = ctrl_r[`TB_C_BYP] ? chkFault : xlateFault;

   // size check of the pointer for the bypass path
   addr_check #(.PA_MAX(PA_MAX)) u_chk
   (
      .ptr       (ptr_r),
      .largePa   (ctrl_r[`TB_C_LPA]),
      .physAddr  (physAddr),
      .sizeFault (chkFault)
   );

   // collection state from enable and stopped flag
   always_comb
   begin
      if (!en)
         state = ST_OFF;
      else if (stat_r[`TB_S_STOP])
         state = ST_STOP;
      else
         state = ST_RUN;
   end

   // per-byte step: collect, check, write, advance
   always_comb
   begin
      accept   = traceValid && traceReady_r;
      issue    = 1'b0;
      faultNow = 1'b0;
      wrapNow  = 1'b0;
      ptrNxt   = ptr_r;
      case (state)
         ST_RUN:
         begin
            if (accept && sizeFault)
               faultNow = 1'b1;
            else if (accept)
            begin
               issue = 1'b1;
               if (ptr_r == limPtr - 64'h1)
               begin
                  ptrNxt  = basePtr;
                  wrapNow = 1'b1;
               end
               else
                  ptrNxt = ptr_r + 64'h1;
            end
         end
         // accepted bytes vanish, pointer held
         ST_STOP: ptrNxt = ptr_r;
         // a byte taken on the lag cycle is dropped
         ST_OFF:  ptrNxt = ptr_r;
         default: ptrNxt = ptr_r;
      endcase
      // software write of the pointer wins over the advance
      if (regWr && awAddr_r == `TB_PTR_LO)
         ptrNxt = {ptr_r[63:32], merged};
      else if (regWr && awAddr_r == `TB_PTR_HI)
         ptrNxt = {merged, ptr_r[31:0]};
   end

   // write channels taken in either order, answered once both held
   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         awready_r <= 1'b1;
         wready_r  <= 1'b1;
         bvalid_r  <= 1'b0;
         bresp_r   <= `TB_RESP_OK;
         awAddr_r  <= 8'h00;
         wData_r   <= 32'h0;
         wStrb_r   <= 4'h0;
      end
      else
      begin
         if (awvalid && awready_r)
         begin
            awAddr_r  <= awaddr;
            awready_r <= 1'b0;
         end
         if (wvalid && wready_r)
         begin
            wData_r  <= wdata;
            wStrb_r  <= wstrb;
            wready_r <= 1'b0;
         end
         if (regWr)
         begin
            bvalid_r <= 1'b1;
            bresp_r  <= isMapped(awAddr_r) ? `TB_RESP_OK : `TB_RESP_ERR;
         end
         else if (bvalid_r && bready)
         begin
            bvalid_r  <= 1'b0;
            awready_r <= 1'b1;
            wready_r  <= 1'b1;
         end
      end
   end

   // read channel, data one cycle after the address
   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         arready_r <= 1'b1;
         rvalid_r  <= 1'b0;
         rdata_r   <= 32'h0;
         rresp_r   <= `TB_RESP_OK;
      end
      else if (arvalid && arready_r)
      begin
         arready_r <= 1'b0;
         rvalid_r  <= 1'b1;
         rdata_r   <= regRead(araddr);
         rresp_r   <= isMapped(araddr) ? `TB_RESP_OK : `TB_RESP_ERR;
      end
      else if (rvalid_r && rready)
      begin
         rvalid_r  <= 1'b0;
         arready_r <= 1'b1;
      end
   end

   // control, pointer fields, counter and attributes
   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         ctrl_r  <= `TB_CTRL_RST;
         ptr_r   <= 64'h0;
         baseF_r <= 52'h0;
         limF_r  <= 52'h0;
         trg_r   <= 32'h0;
         attr_r  <= 8'h00;
      end
      else
      begin
         ptr_r <= ptrNxt;
         if (regWr && awAddr_r == `TB_CTRL)
            ctrl_r <= merged[4:0];
         if (regWr && awAddr_r == `TB_BASE_LO)
            baseF_r[19:0] <= merged[31:12];
         if (regWr && awAddr_r == `TB_BASE_HI)
            baseF_r[51:20] <= merged;
         if (regWr && awAddr_r == `TB_LIM_LO)
            limF_r[19:0] <= merged[31:12];
         if (regWr && awAddr_r == `TB_LIM_HI)
            limF_r[51:20] <= merged;
         if (regWr && awAddr_r == `TB_ATTR)
            attr_r <= merged[7:0];
         if (regWr && awAddr_r == `TB_TRG)
            trg_r <= merged;
         else if (issue && trg_r != 32'h0)
            trg_r <= trg_r - 32'h1;
      end
   end

   // status flags: hardware set wins over a software clear
   always_comb
   begin
      statNxt = (regWr && awAddr_r == `TB_STAT) ? merged[3:0] : stat_r;
      if (wrapNow)
         statNxt[`TB_S_WRAP] = 1'b1;
      if (faultNow)
      begin
         statNxt[`TB_S_FAULT] = 1'b1;
         statNxt[`TB_S_STOP]  = 1'b1;
      end
      if (wrapNow && ctrl_r[`TB_C_FILL])
      begin
         statNxt[`TB_S_FULL] = 1'b1;
         statNxt[`TB_S_STOP] = 1'b1;
      end
   end

   // status register
   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
         stat_r <= `TB_STAT_RST;
      else
         stat_r <= statNxt;
   end

   // memory write port: one byte in flight
   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         memValid_r <= 1'b0;
         memAddr_r  <= 64'h0;
         memData_r  <= 8'h00;
         memAttr_r  <= `TB_DEV_ATTR;
      end
      else if (issue)
      begin
         memValid_r <= 1'b1;
         memData_r  <= traceData;
         if (ctrl_r[`TB_C_BYP])
         begin
            memAddr_r <= physAddr;
            memAttr_r <= attr_r;
         end
         else
         begin
            memAddr_r <= xlatePa;
            memAttr_r <= stage1On ? xlateAttr : `TB_DEV_ATTR;
         end
      end
      else if (memReady)
         memValid_r <= 1'b0;
   end

   // accept offer only when the write stage will be free
   assign memBusyNxt = issue || (memValid_r && !memReady);
   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
         traceReady_r <= 1'b0;
      else
         traceReady_r <= en && !memBusyNxt;
   end

   // translation request, event pulse, interrupt, pin sync
   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         xlateVa_r   <= 64'h0;
         xlateReq_r  <= 1'b0;
         wrapEvent_r <= 1'b0;
         mgmtIrq_r   <= 1'b0;
         selfOk_s1   <= 1'b0;
         selfOk_s2   <= 1'b0;
      end
      else
      begin
         selfOk_s1 <= selfHostedOk;
         selfOk_s2 <= selfOk_s1;
         // top byte follows bit 55 when ignored
         xlateVa_r <= ctrl_r[`TB_C_TBI] ? {{8{ptrNxt[55]}}, ptrNxt[55:0]} : ptrNxt;
         xlateReq_r  <= en && !ctrl_r[`TB_C_BYP];
         wrapEvent_r <= wrapNow;
         mgmtIrq_r   <= stat_r[`TB_S_FAULT] || stat_r[`TB_S_FULL];
      end
   end

   assign awready = awready_r;
   assign wready = wready_r;
   assign bvalid = bvalid_r;
   assign bresp = bresp_r;
   assign arready = arready_r;
   assign rvalid = rvalid_r;
   assign rdata = rdata_r;
   assign rresp = rresp_r;
   assign traceReady = traceReady_r;
   assign memValid = memValid_r;
   assign memAddr = memAddr_r;
   assign memData = memData_r;
   assign memAttr = memAttr_r;
   assign xlateVa = xlateVa_r;
   assign xlateReq = xlateReq_r;
   assign wrapEvent = wrapEvent_r;
   assign mgmtIrq = mgmtIrq_r;

   // checks on the collection path
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!nrst);
   logic swPtr;
   assign swPtr = regWr && (awAddr_r == `TB_PTR_LO || awAddr_r == `TB_PTR_HI);

   a_en_follow: assert property (ctrl_r[`TB_C_EN] && selfOk_s2 && !memValid_r && !issue |=> traceReady_r)
      else $error("enabled unit not ready");
   a_off_noready: assert property (!en |=> !traceReady_r)
      else $error("ready while disabled");
   a_full_refuse: assert property (memValid_r && !memReady |=> !traceReady_r)
      else $error("ready while write stage full");
   a_run_write: assert property (state == ST_RUN && accept && !sizeFault
      |=> memValid_r && memData_r == $past(traceData))
      else $error("accepted byte not written");
   a_stop_drop: assert property (state == ST_STOP && accept && !memValid_r |=> !memValid_r)
      else $error("write while stopped");
   a_stop_hold: assert property (state == ST_STOP && !swPtr |=> ptr_r == $past(ptr_r))
      else $error("pointer moved while stopped");
   a_ptr_incr: assert property (issue && ptr_r != limPtr - 64'h1 && !swPtr
      |=> ptr_r == $past(ptr_r) + 64'h1 && !wrapEvent_r)
      else $error("pointer not advanced by one");
   a_ptr_wrap: assert property (issue && ptr_r == limPtr - 64'h1 && !swPtr
      |=> ptr_r == basePtr && stat_r[`TB_S_WRAP] && wrapEvent_r)
      else $error("wrap not taken");
   a_base_align: assert property (basePtr[11:0] == 12'h000 && limPtr[11:0] == 12'h000)
      else $error("pointer low bits nonzero");
   a_byp_attr: assert property (issue && ctrl_r[`TB_C_BYP] |=> memAttr_r == $past(attr_r))
      else $error("bypass attribute wrong");
   a_size_fault: assert property (state == ST_RUN && accept && sizeFault
      |=> stat_r[`TB_S_FAULT] && stat_r[`TB_S_STOP] ##1 mgmtIrq_r)
      else $error("size fault not raised");
   a_trg_dec: assert property (issue && trg_r > 32'h1 && !regWr |=> trg_r == $past(trg_r) - 32'h1)
      else $error("trigger count not decremented");

   c_write: cover property (issue ##1 memValid_r && memReady);
   c_wrap: cover property (wrapEvent_r);
   c_fault: cover property (faultNow);
   c_discard: cover property (state == ST_STOP && accept);
endmodule : trace_buffer_writer

// ---- bench/far_side_model.sv ----
// far side model: trace byte source, translator and byte-wide memory sink
`timescale 1ns/1ps
module far_side_model
   import trace_buffer_pkg::*;
(
   input  wire logic       mclk,        // processor clock
   input  wire logic       nrst,        // async reset, active low
   input  wire logic [7:0] budget,      // total bytes the source may offer
   input  wire logic       slowMem,     // memory stalls every other cycle
   input  wire logic       traceReady,  // unit takes the offered byte
   input  wire addr_t      xlateVa,     // address to translate
   input  wire logic       xlateReq,    // translation wanted
   output logic            traceValid,  // byte offered
   output logic [7:0]      traceData,   // offered byte, counts up per take
   output logic [7:0]      taken,       // bytes taken so far
   output addr_t           xlatePa,     // translated address
   output logic [7:0]      xlateAttr,   // translated attributes
   output logic            xlateFault,  // translation fault
   output logic            memReady     // memory accepts the write
);
   localparam addr_t PA_OFS = 64'h0000_0000_0010_0000;  // virtual to physical offset

   // translator answers in the same cycle; unknown request gives a changing pattern
   assign xlatePa    = xlateReq ? xlateVa + PA_OFS : ~xlateVa;
   assign xlateAttr  = 8'h44;
   assign xlateFault = 1'b0;

   // source holds a refused byte until taken, never drops it; memory may stall
   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         traceValid <= 1'b0;
         traceData  <= 8'h00;
         taken      <= 8'h00;
         memReady   <= 1'b0;
      end
      else
      begin
         if (traceValid && traceReady)  // byte taken: move to the next one
         begin
            traceData  <= traceData + 8'h01;
            taken      <= taken + 8'h01;
            traceValid <= (taken + 8'h01) < budget;
         end
         else if (!traceValid)  // offer only while budget remains
         begin
            traceValid <= taken < budget;
         end
         // a refused byte stays offered unchanged, never dropped
         memReady <= slowMem ? ~memReady : 1'b1;
      end
   end
endmodule : far_side_model

// ---- bench/tb_top.sv ----
// testbench of the trace buffer writer: register bus tasks and byte scenarios
`timescale 1ns/1ps
`include "trace_buffer_regs.svh"
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin failCount++; \
   $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb_top
   import trace_buffer_pkg::*;
;
   logic mclk = 1'b0, nrst = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00, traceData, xlateAttr, memData, memAttr, budget = 8'h00, taken;
   logic [31:0] wdata = 32'h0, rdata;
   logic [3:0] wstrb = 4'h0;
   logic [1:0] bresp, rresp;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b1, arvalid = 1'b0, rready = 1'b1;
   logic awready, wready, bvalid, arready, rvalid, selfHostedOk = 1'b1, stage1On = 1'b0, slowMem = 1'b0;
   logic traceValid, traceReady, xlateReq, xlateFault, memValid, memReady, wrapEvent, mgmtIrq;
   addr_t xlateVa, xlatePa, memAddr;
   int failCount = 0, comparisons = 0, wraps = 0;
   addr_t qAddr[$];       // written addresses
   logic [7:0] qData[$];  // written bytes
   logic [7:0] qAttr[$];  // written attributes
   logic [31:0] rd;
   logic [1:0] rsp;

   always #4 mclk = ~mclk;  // 125 MHz

   trace_buffer_writer #(.PA_MAX(40)) DUT (.mclk(mclk), .nrst(nrst), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
      .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
      .rresp(rresp), .rvalid(rvalid), .rready(rready), .selfHostedOk(selfHostedOk), .traceValid(traceValid),
      .traceData(traceData), .traceReady(traceReady), .xlateVa(xlateVa), .xlateReq(xlateReq),
      .xlatePa(xlatePa), .xlateAttr(xlateAttr), .xlateFault(xlateFault), .stage1On(stage1On),
      .memValid(memValid), .memAddr(memAddr), .memData(memData), .memAttr(memAttr), .memReady(memReady),
      .wrapEvent(wrapEvent), .mgmtIrq(mgmtIrq));

   far_side_model FAR (.mclk(mclk), .nrst(nrst), .budget(budget), .slowMem(slowMem),
      .traceReady(traceReady), .xlateVa(xlateVa), .xlateReq(xlateReq), .traceValid(traceValid),
      .traceData(traceData), .taken(taken), .xlatePa(xlatePa), .xlateAttr(xlateAttr),
      .xlateFault(xlateFault), .memReady(memReady));

   // record every memory write and every wrap pulse
   always @(posedge mclk)
   begin
      if (nrst && memValid && memReady)
      begin
         qAddr.push_back(memAddr);
         qData.push_back(memData);
         qAttr.push_back(memAttr);
      end
      if (nrst && wrapEvent)
         wraps++;
   end

   // verdict and end of run
   task automatic finalReport();
      if (failCount == 0 && comparisons > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : finalReport

   // hang cut short: counts as a mismatch
   task automatic timedOut();
      failCount++;
      finalReport();
   endtask : timedOut

   // register write: address and data offered together, each released when taken
   task automatic axWrite(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      int n;
      n = 0;
      awaddr  <= a;
      wdata   <= d;
      wstrb   <= 4'hf;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      forever
      begin
         @(posedge mclk);
         if (awvalid && awready)
            awvalid <= 1'b0;
         if (wvalid && wready)
            wvalid <= 1'b0;
         if (bvalid && bready)
            break;
         if (++n > 100)
            timedOut();
      end
      r = bresp;
   endtask : axWrite

   // register read: held until taken, data taken at the response edge
   task automatic axRead(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      n = 0;
      araddr  <= a;
      arvalid <= 1'b1;
      forever
      begin
         @(posedge mclk);
         if (arvalid && arready)
            arvalid <= 1'b0;
         if (rvalid && rready)
            break;
         if (++n > 100)
            timedOut();
      end
      d = rdata;
      r = rresp;
   endtask : axRead

   // offer more bytes and wait until the source has handed them all over
   task automatic sendBytes(input int n);
      int k;
      k = 0;
      budget <= budget + 8'(n);
      @(posedge mclk);
      while (taken !== budget)
      begin
         @(posedge mclk);
         if (++k > 300)
            timedOut();
      end
      repeat (6) @(posedge mclk);
   endtask : sendBytes

   // main sequence
   initial
   begin
      repeat (12) @(posedge mclk);
      nrst <= 1'b1;
      @(posedge mclk);
      axRead(`TB_CTRL, rd, rsp);       `CHK(rd, 32'h0)
      axRead(`TB_STAT, rd, rsp);       `CHK(rd, 32'h0)
      axRead(8'h40, rd, rsp);          `CHK(rsp, `TB_RESP_ERR)
      axWrite(8'h40, 32'h1, rsp);      `CHK(rsp, `TB_RESP_ERR)
      axWrite(`TB_BASE_LO, 32'h0000_1345, rsp);
      axRead(`TB_BASE_LO, rd, rsp);    `CHK(rd, 32'h0000_1000)
      axWrite(`TB_LIM_LO, 32'h0000_2abc, rsp);
      axRead(`TB_LIM_LO, rd, rsp);     `CHK(rd, 32'h0000_2000)
      // bypassed buffer: last two bytes below the limit, then wrap to base
      axWrite(`TB_ATTR, 32'h5a, rsp);
      axWrite(`TB_TRG, 32'h5, rsp);
      axWrite(`TB_PTR_LO, 32'h0000_1ffe, rsp);
      slowMem <= 1'b1;
      axWrite(`TB_CTRL, 32'h3, rsp);
      sendBytes(3);
      `CHK(qAddr.size(), 3)
      for (int i = 0; i < 3; i++)
      begin
         `CHK(qAddr[i], (i < 2) ? 64'h1ffe + 64'(i) : 64'h1000)
         `CHK(qData[i], 8'(i))
         `CHK(qAttr[i], 8'h5a)
      end
      `CHK(wraps, 1)
      axRead(`TB_PTR_LO, rd, rsp);     `CHK(rd, 32'h0000_1001)
      axRead(`TB_STAT, rd, rsp);       `CHK(rd[`TB_S_WRAP], 1'b1)
      axRead(`TB_TRG, rd, rsp);        `CHK(rd, 32'h2)
      // collection stopped: bytes taken and dropped, pointer held
      axWrite(`TB_STAT, 32'h1, rsp);
      sendBytes(2);
      `CHK(qAddr.size(), 3)
      axRead(`TB_PTR_LO, rd, rsp);     `CHK(rd, 32'h0000_1001)
      // bits above the top index are taken as zero
      axWrite(`TB_STAT, 32'h0, rsp);
      slowMem <= 1'b0;
      axWrite(`TB_PTR_LO, 32'h0000_1000, rsp);
      axWrite(`TB_PTR_HI, 32'h8000_0000, rsp);
      sendBytes(1);
      `CHK(qAddr[3], 64'h1000)
      // bits between the physical width and the top index give a size fault
      axWrite(`TB_PTR_HI, 32'h0000_0100, rsp);
      sendBytes(1);
      `CHK(qAddr.size(), 4)
      axRead(`TB_STAT, rd, rsp);       `CHK(rd[3:0], 4'h5)
      `CHK(mgmtIrq, 1'b1)
      // translation on with top byte ignored and stage one off
      axWrite(`TB_STAT, 32'h0, rsp);
      axWrite(`TB_PTR_HI, 32'hab00_0000, rsp);
      axWrite(`TB_CTRL, 32'h5, rsp);
      @(posedge mclk);
      `CHK(xlateReq, 1'b1)
      `CHK(mgmtIrq, 1'b0)
      sendBytes(1);
      `CHK(qAddr[4], 64'h0010_1001)
      `CHK(qAttr[4], `TB_DEV_ATTR)
      // fill mode with stage one on: the wrap stops collection, next byte dropped
      stage1On <= 1'b1;
      axWrite(`TB_PTR_LO, 32'h0000_1fff, rsp);
      axWrite(`TB_PTR_HI, 32'h0, rsp);
      axWrite(`TB_CTRL, 32'h11, rsp);
      sendBytes(2);
      `CHK(qAddr.size(), 6)
      `CHK(qAddr[5], 64'h0010_1fff)
      `CHK(qAttr[5], 8'h44)
      axRead(`TB_STAT, rd, rsp);       `CHK(rd[3:0], 4'hb)
      axRead(`TB_TRG, rd, rsp);        `CHK(rd, 32'h0)
      // self-hosted trace not allowed: unit disabled, nothing taken
      selfHostedOk <= 1'b0;
      repeat (5) @(posedge mclk);
      budget <= budget + 8'h01;
      repeat (20) @(posedge mclk);
      `CHK(traceReady, 1'b0)
      `CHK(taken, budget - 8'h01)
      `CHK(qAddr.size(), 6)
      finalReport();
   end
endmodule : tb_top
